// ===== hw/mfp_core.sv
// How it works
// [RQ1] Four phases make one instruction cycle
// [RQ2] PC advances at start of first phase
// [RQ3] Fetch overlaps execute, one cycle each
// [RQ4] Jump and call take two cycles
// [RQ5] Sequential instruction adds one to PC
// [RQ6] PC is 11 bits, low byte visible
// [RQ7] Jump, call, interrupt, reset load target
// [RQ8] Taken skip replaces next with dummy cycle
// [RQ9] Low byte write jumps within page
// [RQ10] Low byte write inserts one dummy cycle
// [RQ11] Six-level stack, hidden from software
// [RQ12] Call and interrupt push, returns pop
// [RQ13] Reset points stack at its top
// [RQ14] Full stack holds interrupt until return
// [RQ15] Call on full stack loses oldest
// [RQ16] 8-bit ALU writes chosen destination
// [RQ17] ALU outcome updates status flags
// [RQ18] Rotates with or without carry
// [RQ19] Dummy cycle writes nothing, only fetches
//
// The plain strobed port and the register offsets are this design's own decisions.
`include "mfp_consts.svh"
`default_nettype none
module mfp_core
  import mfp_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Register port
  input wire mfp_bus_t i_bus,
  output logic [7:0] o_rdata,
  // Program memory
  output logic [`MFP_PC_W-1:0] o_fetch_addr,
  input wire logic [15:0] i_instr,
  // Interrupt
  input wire logic i_int_pin,
  output logic o_int_ack,
  // Status
  output logic [3:0] o_instruction_phase_clocks,
  output logic o_stack_full
);

  mfp_phase_t ph_q;
  logic [3:0] phase_oh_q;
  logic [`MFP_PC_W-1:0] pc_q;
  logic [`MFP_PC_W-1:0] pc_d;
  mfp_instr_t ir_q;
  logic ir_vld_q;
  logic [7:0] acc_q;
  logic [3:0] stat_q;
  logic [7:0] gpr_q [8];
  logic [`MFP_PC_W-1:0] stk_q [6];
  logic [2:0] sp_q;
  logic [2:0] sp_d;
  logic full_q;
  logic [1:0] int_sync_q;
  logic int_prev_q;
  logic int_en_q;
  logic int_flag_q;
  logic ack_q;
  logic pcl_pend_q;
  logic [7:0] pcl_tgt_q;
  logic [7:0] rdata_q;
  logic t4;
  logic exec;
  logic [7:0] opnd;
  mfp_alu_t alu_o;
  logic is_alu;
  logic wr_ins;
  logic pcl_wr_ins;
  logic skip;
  logic flow;
  logic irq_take;
  logic flush_any;
  logic push;
  logic pop;
  logic int_rise;
  logic [2:0] pc_hi;
  logic [`MFP_PC_W-1:0] stk_top;

  // Register read decode, shared by port and ALU
  function automatic logic [7:0] rd_reg(input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `MFP_ADR_PCL: v = pc_q[7:0];
      `MFP_ADR_ACC: v = acc_q;
      `MFP_ADR_STAT: v = {4'h0, stat_q};
      `MFP_ADR_INTC: v = {6'h00, int_flag_q, int_en_q};
      default: v = a[3] ? gpr_q[a[2:0]] : 8'h00;
    endcase
    return v;
  endfunction

  // Port write hit on one register
  function automatic logic bus_hit(input logic [3:0] a);
    return i_bus.wr && (i_bus.addr == a);
  endfunction

  // 8-bit ALU with flag update masks
  function automatic mfp_alu_t alu(input mfp_instr_t ins, input logic [7:0] a,
                                   input logic [7:0] m, input logic c);
    mfp_alu_t r;
    logic [8:0] s;
    r = '0;
    s = 9'h000;
    r.c = c;
    case (ins.op)
      OP_ADD, OP_ADC: begin
        s = {1'b0, a} + {1'b0, m} + {8'h00, (ins.op == OP_ADC) & c};
        r.res = s[7:0];
        r.c = s[8];
        r.ov = (a[7] == m[7]) && (s[7] != a[7]);
        r.uc = 1'b1;
        r.uov = 1'b1;
        r.uz = 1'b1;
      end
      OP_SUB, OP_SBC: begin
        s = {1'b0, a} + {1'b0, ~m} + {8'h00, (ins.op == OP_SBC) ? c : 1'b1};
        r.res = s[7:0];
        r.c = s[8];
        r.ov = (a[7] != m[7]) && (s[7] != a[7]);
        r.uc = 1'b1;
        r.uov = 1'b1;
        r.uz = 1'b1;
      end
      OP_AND: begin
        r.res = a & m;
        r.uz = 1'b1;
      end
      OP_OR: begin
        r.res = a | m;
        r.uz = 1'b1;
      end
      OP_XOR: begin
        r.res = a ^ m;
        r.uz = 1'b1;
      end
      OP_CPL: begin
        r.res = ~m;
        r.uz = 1'b1;
      end
      OP_INC: begin
        r.res = m + 8'h01;
        r.uz = 1'b1;
      end
      OP_DEC: begin
        r.res = m - 8'h01;
        r.uz = 1'b1;
      end
      OP_ROT: begin
        case (mfp_rot_t'(ins.arg[5:4])) // [RQ18]
          ROT_RR: r.res = {m[0], m[7:1]};
          ROT_RRC: begin
            r.res = {c, m[7:1]};
            r.c = m[0];
            r.uc = 1'b1;
          end
          ROT_RL: r.res = {m[6:0], m[7]};
          ROT_RLC: begin
            r.res = {m[6:0], c};
            r.c = m[7];
            r.uc = 1'b1;
          end
          default: r.res = m;
        endcase
      end
      default: r.res = m;
    endcase
    return r;
  endfunction

  // Phase sequencer, one core clock per phase
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      ph_q <= MFP_T1;
      phase_oh_q <= 4'h1;
    end else begin
      case (ph_q) // [RQ1]
        MFP_T1: begin
          ph_q <= MFP_T2;
          phase_oh_q <= 4'h2;
        end
        MFP_T2: begin
          ph_q <= MFP_T3;
          phase_oh_q <= 4'h4;
        end
        MFP_T3: begin
          ph_q <= MFP_T4;
          phase_oh_q <= 4'h8;
        end
        default: begin
          ph_q <= MFP_T1;
          phase_oh_q <= 4'h1;
        end
      endcase
    end
  end

  // Operand read; a process, so that a register written on the load edge is seen
  always_comb begin
    opnd = rd_reg(ir_q.arg[3:0]);
  end

  // Execute decode in the last phase
  assign t4 = (ph_q == MFP_T4);
  assign exec = t4 && ir_vld_q; // [RQ19]
  assign alu_o = alu(ir_q, acc_q, opnd, stat_q[`MFP_ST_C]); // [RQ16]
  assign is_alu = (ir_q.op != OP_NOP) && (ir_q.op <= OP_DEC);
  assign wr_ins = exec && is_alu;
  assign pcl_wr_ins = wr_ins && ir_q.to_mem && (ir_q.arg[3:0] == `MFP_ADR_PCL);
  assign skip = exec && (ir_q.op == OP_SZ) && (opnd == 8'h00); // [RQ8]
  assign flow = exec && ((ir_q.op == OP_JMP) || (ir_q.op == OP_CALL) ||
                         (ir_q.op == OP_RET) || skip || pcl_wr_ins);
  // Interrupt withheld while all levels are taken
  assign irq_take = exec && !flow && !pcl_pend_q && int_en_q && int_flag_q &&
                    (sp_q != `MFP_STK_N); // [RQ14]
  assign flush_any = flow || irq_take || (t4 && pcl_pend_q);
  assign push = (exec && (ir_q.op == OP_CALL)) || irq_take; // [RQ12]
  assign pop = exec && (ir_q.op == OP_RET); // [RQ12]
  assign pc_hi = pc_q[10:8];
  assign stk_top = stk_q[0];

  // Next program counter
  always_comb begin
    pc_d = pc_q + 11'h001; // [RQ5]
    if (pcl_pend_q) begin
      pc_d = {pc_q[10:8], pcl_tgt_q}; // [RQ9]
    end else if (irq_take) begin
      pc_d = `MFP_INT_VEC; // [RQ7]
    end else if (exec && ((ir_q.op == OP_JMP) || (ir_q.op == OP_CALL))) begin
      pc_d = ir_q.arg; // [RQ7]
    end else if (pop) begin
      pc_d = stk_q[0]; // [RQ12]
    end else if (pcl_wr_ins) begin
      pc_d = {pc_q[10:8], alu_o.res}; // [RQ9]
    end
  end

  // PC and instruction register, updated entering the first phase
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      pc_q <= `MFP_RST_VEC; // [RQ7] [RQ6]
      ir_q <= '0;
      ir_vld_q <= 1'b0;
    end else if (t4) begin
      pc_q <= pc_d; // [RQ2]
      ir_q <= mfp_instr_t'(i_instr); // [RQ3]
      ir_vld_q <= !flush_any; // [RQ4] [RQ8] [RQ10]
    end
  end

  // Stack depth, saturating at six
  always_comb begin
    sp_d = sp_q;
    if (push && (sp_q != `MFP_STK_N)) begin
      sp_d = sp_q + 3'd1;
    end else if (pop && (sp_q != 3'd0)) begin
      sp_d = sp_q - 3'd1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      sp_q <= 3'd0; // [RQ13]
      full_q <= 1'b0;
    end else begin
      sp_q <= sp_d; // [RQ11]
      full_q <= (sp_d == `MFP_STK_N);
    end
  end

  // Shift stack; a push when full drops the oldest entry
  for (genvar i = 0; i < 6; i++) begin : g_stk
    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        stk_q[i] <= '0;
      end else if (push) begin
        stk_q[i] <= (i == 0) ? pc_q : stk_q[(i == 0) ? 0 : i - 1]; // [RQ15]
      end else if (pop) begin
        stk_q[i] <= (i == 5) ? '0 : stk_q[(i == 5) ? 5 : i + 1];
      end
    end
  end

  // Accumulator; port write wins over execute
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      acc_q <= 8'h00;
    end else begin
      if (wr_ins && !ir_q.to_mem) begin
        acc_q <= alu_o.res; // [RQ16]
      end else if (wr_ins && (ir_q.arg[3:0] == `MFP_ADR_ACC)) begin
        acc_q <= alu_o.res;
      end
      if (bus_hit(`MFP_ADR_ACC)) begin
        acc_q <= i_bus.wdata;
      end
    end
  end

  // Status flags from ALU outcome
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      stat_q <= 4'h0;
    end else begin
      if (wr_ins) begin
        if (alu_o.uc) begin
          stat_q[`MFP_ST_C] <= alu_o.c; // [RQ17]
        end
        if (alu_o.uz) begin
          stat_q[`MFP_ST_Z] <= (alu_o.res == 8'h00); // [RQ17]
        end
        if (alu_o.uov) begin
          stat_q[`MFP_ST_OV] <= alu_o.ov; // [RQ17]
        end
        if (ir_q.to_mem && (ir_q.arg[3:0] == `MFP_ADR_STAT)) begin
          stat_q <= alu_o.res[3:0];
        end
      end
      if (bus_hit(`MFP_ADR_STAT)) begin
        stat_q <= i_bus.wdata[3:0];
      end
    end
  end

  // General registers as memory operands
  for (genvar g = 0; g < 8; g++) begin : g_gpr
    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        gpr_q[g] <= 8'h00;
      end else if (bus_hit({1'b1, 3'(g)})) begin
        gpr_q[g] <= i_bus.wdata;
      end else if (wr_ins && ir_q.to_mem && (ir_q.arg[3:0] == {1'b1, 3'(g)})) begin
        gpr_q[g] <= alu_o.res; // [RQ16]
      end
    end
  end

  // Interrupt pin synchroniser and edge
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      int_sync_q <= 2'b00;
      int_prev_q <= 1'b0;
    end else begin
      int_sync_q <= {int_sync_q[0], i_int_pin};
      int_prev_q <= int_sync_q[1];
    end
  end
  assign int_rise = int_sync_q[1] && !int_prev_q;

  // Request flag: a new edge beats any clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      int_flag_q <= 1'b0;
    end else begin
      if (irq_take) begin
        int_flag_q <= 1'b0;
      end else if (bus_hit(`MFP_ADR_INTC)) begin
        int_flag_q <= i_bus.wdata[`MFP_IC_FLAG];
      end
      if (int_rise) begin
        int_flag_q <= 1'b1; // [RQ14]
      end
    end
  end

  // Global enable, off on entry, back on at interrupt return
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      int_en_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      ack_q <= irq_take;
      if (irq_take) begin
        int_en_q <= 1'b0;
      end else if (pop && ir_q.arg[0]) begin
        int_en_q <= 1'b1;
      end else if (bus_hit(`MFP_ADR_INTC)) begin
        int_en_q <= i_bus.wdata[`MFP_IC_EN];
      end
    end
  end

  // Low byte write from the port becomes a jump at the next cycle edge
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      pcl_pend_q <= 1'b0;
      pcl_tgt_q <= 8'h00;
    end else if (bus_hit(`MFP_ADR_PCL)) begin
      pcl_pend_q <= 1'b1; // [RQ10]
      pcl_tgt_q <= i_bus.wdata;
    end else if (t4) begin
      pcl_pend_q <= 1'b0;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= i_bus.rd ? rd_reg(i_bus.addr) : 8'h00; // [RQ6]
    end
  end

  // Outputs
  assign o_rdata = rdata_q;
  assign o_fetch_addr = pc_q;
  assign o_int_ack = ack_q;
  assign o_instruction_phase_clocks = phase_oh_q;
  assign o_stack_full = full_q;

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence dummy_s;
    !ir_vld_q [*4] ##1 ir_vld_q;
  endsequence

  sequence phases_s;
    ph_q == MFP_T1 ##1 ph_q == MFP_T2 ##1 ph_q == MFP_T3 ##1 ph_q == MFP_T4;
  endsequence

  phase_walk_a: assert property (t4 |=> phases_s) // [RQ1]
    else $error("phase order broken");
  phase_onehot_a: assert property (phase_oh_q == (4'h1 << ph_q)) // [RQ1]
    else $error("phase output mismatch");
  pc_hold_a: assert property (!t4 |=> $stable(pc_q)) // [RQ2]
    else $error("pc moved mid cycle");
  pc_step_a: assert property (exec && !flush_any |=> pc_q == $past(pc_q) + 11'h001 // [RQ5]
                              && ir_vld_q)
    else $error("sequential pc step wrong");
  branch_flush_a: assert property (flow && !pcl_pend_q |=> dummy_s) // [RQ4]
    else $error("branch did not insert one dummy");
  jump_tgt_a: assert property (exec && ir_q.op == OP_JMP && !pcl_pend_q // [RQ7]
                               |=> pc_q == $past(ir_q.arg))
    else $error("jump target not loaded");
  pcl_page_a: assert property (t4 && pcl_pend_q |=> pc_q[7:0] == $past(pcl_tgt_q) // [RQ9]
                               && pc_q[10:8] == $past(pc_hi) && !ir_vld_q)
    else $error("low byte jump left page");
  stack_rst_a: assert property ($rose(i_rstn) |-> sp_q == 3'd0) // [RQ13]
    else $error("stack not at top after reset");
  irq_full_a: assert property (t4 && sp_q == `MFP_STK_N && int_flag_q && !i_bus.wr // [RQ14]
                               |=> int_flag_q && !o_int_ack)
    else $error("interrupt taken on full stack");
  call_push_a: assert property (push |=> stk_top == $past(pc_q) && sp_q != 3'd0) // [RQ12]
    else $error("push lost pc");
  full_call_a: assert property (push && sp_q == `MFP_STK_N |=> sp_q == `MFP_STK_N // [RQ15]
                                && stk_q[5] == $past(stk_q[4]))
    else $error("overflow push wrong");
  ret_pop_a: assert property (pop && !pcl_pend_q |=> pc_q == $past(stk_top)) // [RQ12]
    else $error("return did not restore pc");
  dummy_quiet_a: assert property (!ir_vld_q && !i_bus.wr // [RQ19]
                                  |=> $stable(acc_q) && $stable(stat_q) && $stable(sp_q))
    else $error("dummy cycle wrote state");
  zero_flag_a: assert property (wr_ins && alu_o.uz && !ir_q.to_mem && !i_bus.wr // [RQ17]
                                |=> stat_q[`MFP_ST_Z] == (acc_q == 8'h00))
    else $error("zero flag wrong");

endmodule
`default_nettype wire

// ===== hw/mfp_consts.svh
`ifndef MFP_CONSTS_SVH
`define MFP_CONSTS_SVH
// Program counter and stack shape
`define MFP_PC_W 11
`define MFP_STK_N 3'd6
`define MFP_STK_MAX 5
`define MFP_RST_VEC 11'h000
`define MFP_INT_VEC 11'h004
// Register port offsets
`define MFP_ADR_PCL 4'h0
`define MFP_ADR_ACC 4'h1
`define MFP_ADR_STAT 4'h2
`define MFP_ADR_INTC 4'h3
// Status and interrupt control bits
`define MFP_ST_C 0
`define MFP_ST_Z 2
`define MFP_ST_OV 3
`define MFP_IC_EN 0
`define MFP_IC_FLAG 1
`endif

// ===== hw/mfp_pkg.sv
`default_nettype none
package mfp_pkg;
  // Four phases of one instruction cycle
  typedef enum logic [1:0] {
    MFP_T1 = 2'b00,
    MFP_T2 = 2'b01,
    MFP_T3 = 2'b10,
    MFP_T4 = 2'b11
  } mfp_phase_t;
  // Operation codes
  typedef enum logic [3:0] {
    OP_NOP = 4'b0000, OP_ADD = 4'b0001, OP_ADC = 4'b0010, OP_SUB = 4'b0011,
    OP_SBC = 4'b0100, OP_AND = 4'b0101, OP_OR = 4'b0110, OP_XOR = 4'b0111,
    OP_CPL = 4'b1000, OP_ROT = 4'b1001, OP_INC = 4'b1010, OP_DEC = 4'b1011,
    OP_JMP = 4'b1100, OP_CALL = 4'b1101, OP_RET = 4'b1110, OP_SZ = 4'b1111
  } mfp_op_t;
  // Rotate kinds, in arg[5:4]
  typedef enum logic [1:0] {
    ROT_RR = 2'b00, ROT_RRC = 2'b01, ROT_RL = 2'b10, ROT_RLC = 2'b11
  } mfp_rot_t;
  // Instruction word
  typedef struct packed {
    mfp_op_t op;
    logic to_mem;
    logic [10:0] arg;
  } mfp_instr_t;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } mfp_bus_t;
  // ALU result with flag updates
  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic ov;
    logic uc;
    logic uz;
    logic uov;
  } mfp_alu_t;
endpackage
`default_nettype wire

// ===== tb/mfp_core_test.sv
`include "mfp_consts.svh"
`default_nettype none
module mcu_fetch_pc_stack_core_test import mfp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk;
  logic i_rstn;
  logic i_int_pin;
  logic o_int_ack;
  logic o_stack_full;
  mfp_bus_t i_bus;
  logic [7:0] o_rdata;
  logic [10:0] o_fetch_addr;
  logic [15:0] i_instr;
  logic [3:0] o_instruction_phase_clocks;
  logic [15:0] prog [0:2047];
  int failures;
  int num_checks;
  int ack_cnt = 0;

  mfp_core mfp_core_inst (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_bus(i_bus),
    .o_rdata(o_rdata),
    .o_fetch_addr(o_fetch_addr),
    .i_instr(i_instr),
    .i_int_pin(i_int_pin),
    .o_int_ack(o_int_ack),
    .o_instruction_phase_clocks(o_instruction_phase_clocks),
    .o_stack_full(o_stack_full)
  );

  // 20 MHz core clock
  always #25 i_core_clk = ~i_core_clk;

  // Program memory, word ready well before T4
  always @(posedge i_core_clk) begin
    i_instr <= prog[o_fetch_addr];
  end

  // Count acknowledge pulses
  always @(posedge i_core_clk) begin
    if (o_int_ack === 1'b1) begin
      ack_cnt++;
    end
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask

  task automatic timed_out(input string n);
    $display("FAIL %s expected reached seen timeout", n);
    failures++;
    end_of_test();
  endtask

  function automatic logic [15:0] mk(input mfp_op_t op, input logic m, input logic [10:0] ar);
    return {op, m, ar};
  endfunction

  task automatic clr();
    foreach (prog[i]) begin
      prog[i] = 16'h0000;
    end
  endtask

  task automatic do_reset();
    @(posedge i_core_clk);
    i_rstn <= 1'b0;
    repeat (20) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    #1;
  endtask

  // Fetch address of the next instruction cycle
  task automatic next_t1(output logic [15:0] f);
    for (int i = 0; i < 8; i++) begin
      @(posedge i_core_clk);
      #1;
      if (o_instruction_phase_clocks === 4'h1) begin
        f = {5'h00, o_fetch_addr};
        return;
      end
    end
    timed_out("phase");
  endtask

  task automatic wait_addr(input logic [10:0] t);
    for (int i = 0; i < 600; i++) begin
      @(posedge i_core_clk);
      #1;
      if (o_instruction_phase_clocks === 4'h1 && o_fetch_addr === t) begin
        return;
      end
    end
    timed_out("fetch address");
  endtask

  // Register port cycles
  task automatic reg_wr(input logic [3:0] ad, input logic [7:0] wd);
    @(posedge i_core_clk);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: wd};
    @(posedge i_core_clk);
    i_bus <= '0;
  endtask

  task automatic reg_rd(input logic [3:0] ad, output logic [7:0] rd);
    @(posedge i_core_clk);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    @(posedge i_core_clk);
    i_bus <= '0;
    #1;
    rd = o_rdata;
  endtask

  task automatic t_reset();
    logic [15:0] f;
    logic [7:0] r;
    clr();
    do_reset();
    chk("phase", 16'h0001, {12'h000, o_instruction_phase_clocks});
    chk("pc", 16'h0000, {5'h00, o_fetch_addr});
    chk("full", 16'h0000, {15'h0000, o_stack_full});
    for (int k = 1; k < 4; k++) begin
      @(posedge i_core_clk);
      #1;
      chk("phase", 16'h0001 << k, {12'h000, o_instruction_phase_clocks});
    end
    next_t1(f);
    chk("pc", 16'h0001, f);
    reg_rd(4'h4, r);
    chk("unmapped", 16'h0000, {8'h00, r});
  endtask

  task automatic t_jump();
    logic [15:0] f;
    logic [7:0] r;
    logic [15:0] ex [0:5];
    ex = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h06f0, 16'h06f1};
    clr();
    prog[3] = mk(OP_JMP, 1'b0, 11'h6f0);
    do_reset();
    for (int k = 0; k < 6; k++) begin
      next_t1(f);
      chk("jump seq", ex[k], f);
    end
    reg_wr(`MFP_ADR_PCL, 8'h20);
    next_t1(f);
    chk("page jump", 16'h0620, f);
    next_t1(f);
    chk("page next", 16'h0621, f);
    reg_rd(`MFP_ADR_PCL, r);
    chk("low byte", 16'h0021, {8'h00, r});
  endtask

  task automatic t_alu();
    logic [7:0] r;
    clr();
    prog[4] = mk(OP_ADD, 1'b0, 11'h009);
    prog[5] = mk(OP_ADD, 1'b0, 11'h008);
    prog[6] = mk(OP_ROT, 1'b0, 11'h009);
    prog[7] = mk(OP_ROT, 1'b1, 11'h038);
    prog[8] = mk(OP_ROT, 1'b1, 11'h028);
    prog[9] = mk(OP_ROT, 1'b0, 11'h019);
    prog[10] = mk(OP_SUB, 1'b1, 11'h00a);
    prog[11] = mk(OP_XOR, 1'b1, 11'h00a);
    prog[12] = mk(OP_DEC, 1'b1, 11'h00a);
    prog[13] = mk(OP_JMP, 1'b0, 11'h00d);
    do_reset();
    reg_wr(4'h8, 8'h0f);
    reg_wr(4'h9, 8'hf1);
    repeat (80) @(posedge i_core_clk);
    reg_rd(`MFP_ADR_ACC, r);
    chk("acc", 16'h0078, {8'h00, r});
    reg_rd(4'h8, r);
    chk("reg8", 16'h003e, {8'h00, r});
    reg_rd(4'ha, r);
    chk("reg10", 16'h00ff, {8'h00, r});
    reg_rd(`MFP_ADR_STAT, r);
    chk("carry", 16'h0001, {15'h0000, r[`MFP_ST_C]});
    chk("zero", 16'h0000, {15'h0000, r[`MFP_ST_Z]});
  endtask

  task automatic t_skip();
    logic [15:0] f;
    clr();
    prog[4] = mk(OP_SZ, 1'b0, 11'h008);
    prog[5] = mk(OP_JMP, 1'b0, 11'h040);
    prog[6] = mk(OP_SZ, 1'b0, 11'h009);
    prog[7] = mk(OP_JMP, 1'b0, 11'h030);
    do_reset();
    reg_wr(4'h9, 8'h01);
    for (int k = 1; k < 9; k++) begin
      next_t1(f);
      chk("skip seq", 16'(k), f);
    end
    next_t1(f);
    chk("skip end", 16'h0030, f);
  endtask

  // Call chain 0x00 -> 0x10 -> ... -> 0x60 leaves six levels in use
  task automatic chain(input int n);
    for (int k = 0; k < n; k++) begin
      prog[16 * k] = mk(OP_CALL, 1'b0, 11'(16 * k + 16));
    end
  endtask

  task automatic t_stack();
    logic [15:0] f;
    clr();
    chain(7);
    prog[16'h70] = mk(OP_RET, 1'b0, 11'h000);
    for (int k = 2; k < 7; k++) begin
      prog[16 * k + 1] = mk(OP_RET, 1'b0, 11'h000);
    end
    prog[16'h11] = mk(OP_JMP, 1'b0, 11'h07f);
    do_reset();
    wait_addr(11'h060);
    chk("full", 16'h0001, {15'h0000, o_stack_full});
    wait_addr(11'h070);
    chk("overflow", 16'h0001, {15'h0000, o_stack_full});
    next_t1(f);
    for (int k = 6; k > 0; k--) begin
      next_t1(f);
      chk("return", 16'(16 * k + 1), f);
      next_t1(f);
      chk("return next", 16'(16 * k + 2), f);
      if (k == 6) begin
        chk("not full", 16'h0000, {15'h0000, o_stack_full});
      end
    end
    next_t1(f);
    chk("oldest lost", 16'h007f, f);
  endtask

  task automatic t_int();
    logic [7:0] r;
    clr();
    chain(6);
    prog[16'h6c] = mk(OP_RET, 1'b0, 11'h000);
    prog[`MFP_INT_VEC] = mk(OP_RET, 1'b0, 11'h001);
    do_reset();
    reg_wr(`MFP_ADR_INTC, 8'h01);
    wait_addr(11'h060);
    chk("full", 16'h0001, {15'h0000, o_stack_full});
    @(posedge i_core_clk);
    i_int_pin <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    i_int_pin <= 1'b0;
    wait_addr(11'h06c);
    reg_rd(`MFP_ADR_INTC, r);
    chk("flag held", 16'h0003, {8'h00, r});
    chk("no ack", 16'h0000, 16'(ack_cnt));
    wait_addr(`MFP_INT_VEC);
    repeat (2) @(posedge i_core_clk);
    #1;
    chk("ack", 16'h0001, 16'(ack_cnt));
    chk("int push", 16'h0001, {15'h0000, o_stack_full});
    repeat (40) @(posedge i_core_clk);
    reg_rd(`MFP_ADR_INTC, r);
    chk("int return", 16'h0001, {8'h00, r});
  endtask

  // Main sequence
  initial begin
    i_core_clk = 1'b0;
    i_rstn = 1'b0;
    i_bus = '0;
    i_int_pin = 1'b0;
    failures = 0;
    num_checks = 0;
    t_reset();
    t_jump();
    t_alu();
    t_skip();
    t_stack();
    t_int();
    end_of_test();
  end
endmodule
`default_nettype wire
